//--- include/qgc_pkg.sv
// qgc_pkg: constants and types shared by the quad gain control port
package qgc_pkg;
    localparam int NUM_CHAN = 4;
    localparam int ATTEN_W = 5;
    localparam int STEP_FIELD_W = 2;

    // register addresses carried in command bits 2:0
    localparam logic [2:0] ADDR_CHAN_A = 3'h0;
    localparam logic [2:0] ADDR_CHAN_B = 3'h1;
    localparam logic [2:0] ADDR_CHAN_C = 3'h2;
    localparam logic [2:0] ADDR_CHAN_D = 3'h3;
    localparam logic [2:0] ADDR_STEP_ADJ = 3'h4;
    localparam logic [2:0] ADDR_RST = 3'h0;

    // command byte layout
    localparam int CMD_RW_BIT = 7;
    localparam int CMD_ZERO_HI = 6;
    localparam int CMD_ZERO_LO = 3;
    localparam int CMD_ADDR_HI = 2;

    // access length in serial clocks
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] ACCESS_BITS = 5'h10;

    // reset values
    localparam logic [7:0] CHAN_REG_RST = 8'h00;
    localparam logic [7:0] STEP_REG_RST = 8'h00;

    // fast adjust step codes
    localparam logic [1:0] STEP_HOLD = 2'h0;
    localparam logic [1:0] STEP_DOWN = 2'h1;
    localparam logic [1:0] STEP_UP = 2'h2;
    localparam logic [4:0] ATTEN_MAX = 5'h1F;
    localparam logic [4:0] ATTEN_MIN = 5'h00;

    // channel control register, also the gain word sent to the analog side
    typedef struct packed {
        logic rsvd;
        logic power_hi;
        logic enable;
        logic [4:0] atten;
    } qgc_chan_t;

    // three-level enable pin seen through two comparators: low 00, mid 01, high 11
    typedef struct packed {
        logic above_high;
        logic above_low;
    } qgc_tri_t;

    // every pin that crosses into clk_sys
    typedef struct packed {
        logic mode;
        logic [4:0] atten;
        qgc_tri_t [3:0] power_sel;
    } qgc_pins_t;

    // strap low, attenuation pins pulled high, enables at ground
    localparam qgc_pins_t PINS_RST = '{mode: 1'b0, atten: 5'h1F, power_sel: 8'h00};

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_CMD = 2'b01,
        SPI_DATA = 2'b11,
        SPI_FULL = 2'b10
    } qgc_spi_state_t;
endpackage : qgc_pkg

//--- hw/qgc_port.sv
// qgc_port: pin-level control port of a four-channel variable gain amplifier
//
// Overview of operation
// RULE_01 - strap low selects parallel control, high selects serial; strap defaults low.
// RULE_02 - four shared pins are upper attenuation bits or the serial port, by mode.
// RULE_03 - parallel mode applies the 5-bit pin word to the gain at once.
// RULE_04 - host switches parallel bits together, optionally disabling the channel meanwhile.
// RULE_05 - undriven attenuation pins read high, selecting all-ones attenuation.
// RULE_06 - enable pin low disables, high selects high power, mid selects low power.
// RULE_07 - a disabled channel keeps its last attenuation and resumes with it.
// RULE_08 - serial mode ignores enable pins; channel registers give power and enable.
// RULE_09 - select is active low; the device joins a transfer only while it is low.
// RULE_10 - input data sampled on rising serial clock, output changes on falling.
// RULE_11 - host may park the serial clock low between transfers.
// RULE_12 - each select fall starts a fresh 16-clock access: command then data.
// RULE_13 - select released before sixteen clocks causes no address update, no write.
// RULE_14 - select rise captures the address and, for writes, stores the data byte.
// RULE_15 - serial output is driven only while select is low.
// RULE_16 - addressed register shifts out msb first on the second eight falling edges.
// RULE_17 - stored address after power-up is zero, channel A.
// RULE_18 - command bit 7 read, bits 6:3 zero, bits 2:0 select register.
// RULE_19 - channel register: reserved zero, power level, enable, 5-bit attenuation.
// RULE_20 - fast adjust holds 2-bit codes: D 7:6, C 5:4, B 3:2, A 1:0.
// RULE_21 - code 00 holds, 01 lowers, 10 raises attenuation one step; 11 reserved.
// RULE_22 - attenuation spans 31 dB over 32 uniform codes.
// RULE_23 - fast adjust saturates at codes zero and thirty-one, never wraps.
// RULE_24 - serial mode gain uses the channel register bits after the write completes.
`timescale 1ns/1ps
module qgc_port
    import qgc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic mode_sel,
    input wire logic atten_bit0,
    input wire logic atten_bit1,
    input wire logic atten_bit2,
    input wire logic atten_bit3,
    input wire logic atten_bit4_i,
    output logic atten_bit4_o,
    output logic atten_bit4_oe,
    input wire qgc_tri_t power_sel_chan_a,
    input wire qgc_tri_t power_sel_chan_b,
    input wire qgc_tri_t power_sel_chan_c,
    input wire qgc_tri_t power_sel_chan_d,
    output qgc_chan_t [NUM_CHAN-1:0] gain_out,
    output logic [2:0] stored_addr
);

    // decode of a command byte, shared by commit logic and checks
    function automatic logic cmd_valid(input logic [7:0] cmd);
        cmd_valid = (cmd[CMD_ZERO_HI:CMD_ZERO_LO] == 4'h0)
            && (cmd[CMD_ADDR_HI:0] <= ADDR_STEP_ADJ); // RULE_18
    endfunction : cmd_valid

    // saturating one-step move of an attenuation code
    function automatic logic [4:0] step_atten(input logic [4:0] atten, input logic [1:0] code);
        step_atten = atten;
        if (code == STEP_DOWN && atten != ATTEN_MIN) begin // RULE_21 RULE_23
            step_atten = atten - 5'h01;
        end else if (code == STEP_UP && atten != ATTEN_MAX) begin // RULE_21 RULE_23
            step_atten = atten + 5'h01;
        end
    endfunction : step_atten

    qgc_pins_t pins_raw;
    qgc_pins_t sync1_q;
    qgc_pins_t sync2_q;
    logic sclk_q;
    logic csn_q;
    logic serial;
    logic sclk_s;
    logic csn_s;
    logic sdi_s;
    logic sel_active;
    logic cs_fall;
    logic cs_rise;
    logic sclk_rise;
    logic sclk_fall;
    logic commit;
    logic wr_en;
    qgc_spi_state_t state_q;
    logic [4:0] bit_cnt_q;
    logic [15:0] shift_q;
    logic [7:0] out_q;
    logic oe_q;
    logic [2:0] addr_q;
    qgc_chan_t [NUM_CHAN-1:0] chan_q;
    logic [7:0] step_q;
    qgc_chan_t [NUM_CHAN-1:0] gain_q;
    qgc_tri_t [NUM_CHAN-1:0] sel_s;

    // readback of any register; unmapped codes read zero
    function automatic logic [7:0] reg_read(input logic [2:0] addr);
        reg_read = 8'h00;
        if (addr == ADDR_STEP_ADJ) begin
            reg_read = step_q;
        end else if (addr <= ADDR_CHAN_D) begin
            reg_read = chan_q[addr[1:0]];
        end
    endfunction : reg_read

    assign pins_raw = '{mode: mode_sel,
        atten: {atten_bit4_i, atten_bit3, atten_bit2, atten_bit1, atten_bit0},
        power_sel: {power_sel_chan_d, power_sel_chan_c, power_sel_chan_b, power_sel_chan_a}};

    // two-flop synchronisers; reset values follow the pad pulls
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_q <= PINS_RST; // RULE_05 RULE_01
            sync2_q <= PINS_RST;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    assign serial = sync2_q.mode; // RULE_01
    assign sclk_s = sync2_q.atten[1]; // RULE_02
    assign csn_s = sync2_q.atten[2];
    assign sdi_s = sync2_q.atten[3];
    assign sel_s = sync2_q.power_sel;

    // third stage for edge finding on the synchronised serial pins
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            csn_q <= 1'b1;
        end else begin
            sclk_q <= sclk_s;
            csn_q <= csn_s;
        end
    end

    assign sel_active = serial && !csn_s; // RULE_09
    assign cs_fall = sel_active && csn_q; // RULE_12
    assign cs_rise = serial && csn_s && !csn_q;
    // clock edges count only under select, so a parked clock is harmless
    assign sclk_rise = sel_active && sclk_s && !sclk_q; // RULE_10 RULE_11
    assign sclk_fall = sel_active && !sclk_s && sclk_q; // RULE_10
    assign commit = cs_rise && (state_q == SPI_FULL); // RULE_13
    assign wr_en = commit && cmd_valid(shift_q[15:8]) && !shift_q[8+CMD_RW_BIT];

    // access sequencer and input shifter; clocks past sixteen are ignored
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !serial) begin
            state_q <= SPI_IDLE;
            bit_cnt_q <= 5'h00;
            shift_q <= 16'h0000;
        end else if (cs_fall) begin
            state_q <= SPI_CMD; // RULE_12
            bit_cnt_q <= 5'h00;
        end else if (csn_s) begin
            state_q <= SPI_IDLE;
        end else if (sclk_rise && (state_q == SPI_CMD || state_q == SPI_DATA)) begin
            shift_q <= {shift_q[14:0], sdi_s}; // RULE_10
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q + 5'h01 == CMD_BITS) begin
                state_q <= SPI_DATA;
            end else if (bit_cnt_q + 5'h01 == ACCESS_BITS) begin
                state_q <= SPI_FULL; // RULE_12
            end
        end
    end

    // output shifter: loaded on the falling edge after the command byte
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !sel_active) begin
            out_q <= 8'h00;
        end else if (sclk_fall) begin
            if (state_q == SPI_DATA && bit_cnt_q == CMD_BITS) begin
                out_q <= reg_read(shift_q[2:0]); // RULE_16
            end else begin
                out_q <= {out_q[6:0], 1'b0}; // RULE_16
            end
        end
    end

    // output enable follows select; parallel mode never drives the shared pin
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= sel_active; // RULE_15 RULE_02
        end
    end

    assign atten_bit4_o = out_q[7];
    assign atten_bit4_oe = oe_q;

    // stored address, updated only by a complete access
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            addr_q <= ADDR_RST; // RULE_17
        end else if (commit && cmd_valid(shift_q[15:8])) begin
            addr_q <= shift_q[8+CMD_ADDR_HI:8]; // RULE_14
        end
    end

    assign stored_addr = addr_q;

    // fast adjust register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            step_q <= STEP_REG_RST;
        end else if (wr_en && shift_q[10:8] == ADDR_STEP_ADJ) begin
            step_q <= shift_q[7:0]; // RULE_20
        end
    end

    // channel registers: direct write or one fast adjust step per write
    generate
        for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    chan_q[i] <= CHAN_REG_RST;
                end else if (wr_en && shift_q[10:8] == 3'(i)) begin
                    chan_q[i] <= {1'b0, shift_q[6:0]}; // RULE_14 RULE_19
                end else if (wr_en && shift_q[10:8] == ADDR_STEP_ADJ) begin
                    chan_q[i].atten <= step_atten(chan_q[i].atten,
                        shift_q[STEP_FIELD_W*i +: STEP_FIELD_W]); // RULE_20 RULE_22
                end
            end

            // gain word; pin bits are synchronised one by one, so a skewed
            // host change shows as a brief intermediate code
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    gain_q[i] <= CHAN_REG_RST;
                end else if (serial) begin
                    gain_q[i] <= chan_q[i]; // RULE_08 RULE_24
                end else begin
                    gain_q[i].rsvd <= 1'b0;
                    gain_q[i].power_hi <= sel_s[i].above_high; // RULE_06
                    gain_q[i].enable <= sel_s[i].above_low; // RULE_06
                    if (sel_s[i].above_low) begin
                        gain_q[i].atten <= sync2_q.atten; // RULE_03 RULE_05 RULE_04
                    end // RULE_07
                end
            end
        end
    endgenerate

    assign gain_out = gain_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    parallel_apply_a: assert property ( // RULE_03
        (!serial && sel_s[0].above_low) |=> gain_q[0].atten == $past(sync2_q.atten))
        else $error("parallel attenuation not applied");

    enable_level_a: assert property ( // RULE_06
        (!serial && sel_s[1].above_high) |=> (gain_q[1].power_hi && gain_q[1].enable))
        else $error("high enable level not applied");

    disabled_hold_a: assert property ( // RULE_07
        (!serial && !sel_s[0].above_low) |=> $stable(gain_q[0].atten))
        else $error("disabled channel lost attenuation");

    serial_regs_a: assert property ( // RULE_08
        (serial && $past(serial)) |-> gain_q[2] == $past(chan_q[2]))
        else $error("serial gain not from register");

    pin_idle_a: assert property ( // RULE_02
        (!serial ##1 !serial) |-> !atten_bit4_oe)
        else $error("shared pin driven in parallel mode");

    sdo_release_a: assert property ( // RULE_15
        (serial && csn_s) ##1 csn_s |-> !atten_bit4_oe)
        else $error("serial output driven while deselected");

    fresh_access_a: assert property ( // RULE_12
        cs_fall |=> (state_q == SPI_CMD && bit_cnt_q == 5'h00))
        else $error("select fall did not restart access");

    rise_sample_a: assert property ( // RULE_10
        (sclk_rise && state_q == SPI_CMD) |=> shift_q[0] == $past(sdi_s))
        else $error("input bit not sampled on rising edge");

    short_access_a: assert property ( // RULE_13
        (cs_rise && state_q != SPI_FULL)
            |=> ($stable(chan_q) && $stable(addr_q) && $stable(step_q)))
        else $error("short access changed state");

    addr_capture_a: assert property ( // RULE_14
        (commit && cmd_valid(shift_q[15:8])) |=> addr_q == $past(shift_q[10:8]))
        else $error("address not captured");

    write_store_a: assert property ( // RULE_19
        (wr_en && shift_q[10:8] == ADDR_CHAN_A) |=> chan_q[0] == {1'b0, $past(shift_q[6:0])})
        else $error("channel write not stored");

    read_load_a: assert property ( // RULE_16
        (sclk_fall && state_q == SPI_DATA && bit_cnt_q == CMD_BITS)
            |=> out_q == reg_read($past(shift_q[2:0])))
        else $error("readback not loaded");

    step_sat_a: assert property ( // RULE_23
        (wr_en && shift_q[10:8] == ADDR_STEP_ADJ && shift_q[1:0] == STEP_UP
            && chan_q[0].atten == ATTEN_MAX) |=> chan_q[0].atten == ATTEN_MAX)
        else $error("fast adjust wrapped");

    step_floor_a: assert property ( // RULE_23
        (wr_en && shift_q[10:8] == ADDR_STEP_ADJ && shift_q[3:2] == STEP_DOWN
            && chan_q[1].atten == ATTEN_MIN) |=> chan_q[1].atten == ATTEN_MIN)
        else $error("fast adjust wrapped below zero");

    step_move_a: assert property ( // RULE_21
        (wr_en && shift_q[10:8] == ADDR_STEP_ADJ && shift_q[5:4] == STEP_UP
            && chan_q[2].atten != ATTEN_MAX)
            |=> chan_q[2].atten == 5'($past(chan_q[2].atten) + 5'h01))
        else $error("fast adjust step not applied");

    step_store_a: assert property ( // RULE_20
        (wr_en && shift_q[10:8] == ADDR_STEP_ADJ) |=> step_q == $past(shift_q[7:0]))
        else $error("fast adjust register not stored");

    deselect_idle_a: assert property ( // RULE_09
        !sel_active |=> state_q == SPI_IDLE)
        else $error("access active while deselected");

    access_full_a: assert property ( // RULE_12
        (sclk_rise && state_q == SPI_DATA && bit_cnt_q == ACCESS_BITS - 5'h01)
            |=> state_q == SPI_FULL)
        else $error("sixteenth clock did not end access");

    sdo_hold_a: assert property ( // RULE_10
        (sel_active && !sclk_fall) |=> $stable(out_q))
        else $error("serial output changed off falling edge");

    sdo_shift_a: assert property ( // RULE_16
        (sclk_fall && !(state_q == SPI_DATA && bit_cnt_q == CMD_BITS))
            |=> out_q == {$past(out_q[6:0]), 1'b0})
        else $error("serial output not shifted msb first");

    sdo_drive_a: assert property ( // RULE_15
        sel_active |=> atten_bit4_oe)
        else $error("serial output not driven under select");

    atten_write_a: assert property ( // RULE_19
        (wr_en && shift_q[10:8] == ADDR_CHAN_D) |=> chan_q[3].atten == $past(shift_q[4:0]))
        else $error("channel attenuation not stored");

    low_power_a: assert property ( // RULE_06
        (!serial && sel_s[2].above_low && !sel_s[2].above_high)
            |=> (gain_q[2].enable && !gain_q[2].power_hi))
        else $error("mid enable level not low power");

    chan_off_a: assert property ( // RULE_06
        (!serial && !sel_s[3].above_low) |=> !gain_q[3].enable)
        else $error("low enable level did not disable");

endmodule : qgc_port

//--- testbench/qgc_host.sv
// qgc_host: behavioural serial host driving the shared control pins
`timescale 1ns/1ps
module qgc_host (
    input wire logic clk_sys,
    input wire logic sdo,
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // idle data line toggles so a stale bit cannot look valid
    always @(posedge clk_sys) begin
        if (cs_n) begin
            sdi <= ~sdi;
        end
    end
    // one access of n clocks; clock is parked low outside frames
    task automatic xfer(input logic [15:0] word, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk_sys);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < n; i++) begin
            sdi <= word[15-i];
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b1;
            if (i >= 8) begin
                rd = {rd[6:0], sdo};
            end
            repeat (4) @(posedge clk_sys);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        cs_n <= 1'b1;
        // covers select-high spacing and commit latency
        repeat (8) @(posedge clk_sys);
    endtask : xfer
endmodule : qgc_host

//--- testbench/qgc_port_bench.sv
// qgc_port_bench: self-checking bench for the quad gain control port
`timescale 1ns/1ps
module qgc_port_bench;
    import qgc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic mode_sel = 1'b0;
    logic [4:0] par = 5'h1F;
    qgc_tri_t [3:0] psel = '0;
    logic sclk, cs_n, sdi, sdo_o, sdo_oe, bit4;
    qgc_chan_t [NUM_CHAN-1:0] gain_out;
    logic [2:0] stored_addr;
    logic [2:0] last = 3'h0;
    logic [7:0] shadow [8] = '{default: 8'h00};
    logic [4:0] hold [4] = '{default: 5'h00};
    logic [4:0] w;
    int k;
    int failures = 0;
    int n_checks = 0;
    // released serial out pin sits at its pull-up
    assign bit4 = sdo_oe ? sdo_o : (mode_sel ? 1'b1 : par[4]);
    qgc_port qgc_port_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .mode_sel(mode_sel), .atten_bit0(par[0]),
        .atten_bit1(mode_sel ? sclk : par[1]), .atten_bit2(mode_sel ? cs_n : par[2]),
        .atten_bit3(mode_sel ? sdi : par[3]), .atten_bit4_i(bit4), .atten_bit4_o(sdo_o),
        .atten_bit4_oe(sdo_oe), .power_sel_chan_a(psel[0]), .power_sel_chan_b(psel[1]),
        .power_sel_chan_c(psel[2]), .power_sel_chan_d(psel[3]), .gain_out(gain_out),
        .stored_addr(stored_addr)
    );
    qgc_host qgc_host_i (.clk_sys(clk_sys), .sdo(bit4), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    function automatic logic [4:0] stepped(input logic [4:0] a, input logic [1:0] c);
        if (c == STEP_DOWN && a != ATTEN_MIN) return a - 5'h01;
        if (c == STEP_UP && a != ATTEN_MAX) return a + 5'h01;
        return a;
    endfunction : stepped
    task automatic par_check();
        for (int c = 0; c < NUM_CHAN; c++) begin
            if (psel[c].above_low) hold[c] = par;
            chk("gain_par", {1'b0, psel[c].above_high, psel[c].above_low, hold[c]},
                gain_out[c]);
        end
    endtask : par_check
    // one serial access, then every visible effect compared
    task automatic acc(input logic [7:0] cmd, input logic [7:0] d, input int n);
        logic ok;
        logic [7:0] rd;
        ok = n == 16 && cmd[6:3] == 4'h0 && cmd[2:0] <= ADDR_STEP_ADJ;
        qgc_host_i.xfer({cmd, d}, n, rd);
        if (n == 16 && cmd[7]) chk("read", ok ? shadow[cmd[2:0]] : 8'h00, rd);
        if (ok && !cmd[7] && cmd[2:0] == ADDR_STEP_ADJ) begin
            shadow[4] = d;
            for (int c = 0; c < NUM_CHAN; c++) begin
                shadow[c][4:0] = stepped(shadow[c][4:0], d[2*c+:2]);
            end
        end else if (ok && !cmd[7]) begin
            shadow[cmd[2:0]] = d & 8'h7F;
        end
        if (ok) last = cmd[2:0];
        for (int c = 0; c < NUM_CHAN; c++) begin
            chk("gain_ser", shadow[c], gain_out[c]);
        end
        chk("addr", {5'h00, last}, {5'h00, stored_addr});
        chk("oe_idle", 8'h00, {7'h00, sdo_oe});
    endtask : acc
    initial begin
        #400000;
        failures++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hE950));
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk("addr_rst", 8'h00, {5'h00, stored_addr});
        for (int t = 0; t < 16; t++) begin
            w = (t == 0) ? 5'h1F : 5'($urandom);
            @(posedge clk_sys);
            par <= w;
            for (int c = 0; c < NUM_CHAN; c++) begin
                k = (t == 0) ? 2 : $urandom_range(2);
                psel[c] <= '{k == 2, k != 0};
            end
            repeat (5) @(posedge clk_sys);
            par_check();
        end
        $display("test parallel done");
        @(posedge clk_sys);
        par <= 5'h1F;
        mode_sel <= 1'b1;
        repeat (6) @(posedge clk_sys);
        for (int a = 0; a < NUM_CHAN; a++) begin
            psel[a] <= '{1'b1, 1'b1};
            acc({5'h00, 3'(a)}, 8'($urandom), 16);
        end
        for (int a = 0; a < 5; a++) acc({5'h10, 3'(a)}, 8'($urandom), 16);
        $display("test serial access done");
        acc(8'h01, 8'h55, 12);
        acc(8'h02, 8'h33, 8);
        acc(8'h09, 8'hAA, 16);
        acc(8'h05, 8'hAA, 16);
        acc(8'h86, 8'h00, 16);
        $display("test refused access done");
        acc(8'h00, 8'h1F, 16);
        acc(8'h01, 8'h60, 16);
        acc(8'h02, 8'h05, 16);
        acc(8'h03, 8'h6A, 16);
        acc(8'h04, 8'hE6, 16);
        acc(8'h04, 8'h16, 16);
        for (int t = 0; t < 4; t++) acc(8'h04, 8'($urandom), 16);
        acc(8'h84, 8'h00, 16);
        $display("test fast adjust done");
        complete_run();
    end
endmodule : qgc_port_bench
